// *** logic/cgc_pkg.sv ***
// Package: register map, field layouts and constants of the clock generation control
package cgc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_SRC_CTRL = 8'h00;
  localparam logic [7:0] OFF_PLL_CTRL = 8'h04;
  localparam logic [7:0] OFF_DIV_CTRL = 8'h08;
  localparam logic [7:0] OFF_MEM_WAIT = 8'h0c;
  localparam logic [7:0] OFF_MSTOP_A = 8'h10;
  localparam logic [7:0] OFF_MSTOP_D = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_IRQ_EN = 8'h1c;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h20;
  localparam logic [7:0] OFF_CUR_SRC = 8'h24;

  // Clock source select codes
  typedef enum logic [1:0] {
    CGC_SRC_LOW_OSC = 2'h0,
    CGC_SRC_HIGH_OSC = 2'h1,
    CGC_SRC_MAIN = 2'h2,
    CGC_SRC_PLL = 2'h3
  } cgc_src_t;

  // PLL control fields
  localparam int PLL_MUL_LSB = 8;
  localparam int PLL_MUL_W = 6;
  localparam int PLL_REF_BIT = 4;
  localparam int PLL_EN_BIT = 0;
  // Multiplier code = 2*factor - 1 : x10 .. x30 in 0.5 steps
  localparam logic [5:0] PLL_MUL_MIN = 6'h13;
  localparam logic [5:0] PLL_MUL_MAX = 6'h3b;
  localparam logic [5:0] PLL_MUL_RST = 6'h13;

  // Status bits
  localparam int ST_OSC_STOP = 0;
  localparam int ST_SW_DONE = 1;
  localparam int ST_MUL_ERR = 2;
  localparam int ST_W = 3;

  // Divider fields: 3 bits each, log2 of the division ratio
  localparam int DIV_W = 3;
  localparam int DIV_N = 7;

  // Module-stop masks for all-module clock stop
  localparam logic [31:0] MSTOP_A_ALL = 32'h2900_0000;
  localparam logic [31:0] MSTOP_D_ALL = 32'h0000_00ff;
  localparam logic [31:0] MSTOP_RST = 32'hffff_ffff;

  // Changeover settle: clocks of quiet before and after a switch
  localparam int SW_GAP_NS = 40;
  localparam int CLK_NS = 5;
  localparam logic [3:0] SW_GAP_CYC = 4'((SW_GAP_NS + CLK_NS - 1) / CLK_NS);

  typedef enum logic [1:0] {
    CGC_RUN,
    CGC_GATE_OFF,
    CGC_GATE_ON
  } cgc_sw_state_t;
endpackage

// *** logic/cgc_div_if.sv ***
// Interface: divider settings and clock enables between control and divider bank
`timescale 1ns/1ps
interface cgc_div_if;
  logic [cgc_pkg::DIV_N*cgc_pkg::DIV_W-1:0] ratio;
  logic gate;
  logic [cgc_pkg::DIV_N-1:0] tick;
  modport ctrl (output ratio, output gate, input tick);
  modport div (input ratio, input gate, output tick);
endinterface

// *** logic/cgc_div_bank.sv ***
// Divider bank: one clock-enable tick per derived clock domain
`timescale 1ns/1ps
module cgc_div_bank
  import cgc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  cgc_div_if.div dv
);
  logic [6:0] base_cnt;
  logic [DIV_N-1:0] next_tick;

  // Tick each 2**ratio base cycles; gated ticks produce no partial pulse
  always_comb begin
    for (int i = 0; i < DIV_N; i++) begin
      next_tick[i] = ~dv.gate &
        ((base_cnt & ((7'h1 << dv.ratio[i*DIV_W +: DIV_W]) - 7'h1)) == 7'h0);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      base_cnt <= 7'h0;
      dv.tick <= '0;
    end else begin
      base_cnt <= dv.gate ? 7'h0 : base_cnt + 7'h1;
      dv.tick <= next_tick;
    end
  end

  a_gate_no_tick: assert property (@(posedge clk) disable iff (sys_rst)
    $past(dv.gate) |-> dv.tick == '0) else $error("tick while gated");
endmodule

// *** logic/cgc_top.sv ***
// Clock generation control: source select, PLL, oscillator-stop fallback, module stop
// Operation
// - Main oscillator stop switches system clock to low-speed internal oscillator.
// - No fallback when PLL from high-speed oscillator drives the system clock.
// - PLL multiplier ten to thirty in half steps; others unsupported.
// - Software may switch system clock to or from PLL at run time.
// - Timers count on timer clock; their bus runs on fast peripheral clock.
`timescale 1ns/1ps
module cgc_top
  import cgc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic main_osc_stopped,
  output cgc_pkg::cgc_src_t clk_src_sel,
  output logic [5:0] pll_multiplier_field,
  output logic pll_enable,
  output logic pll_ref_high_osc,
  output logic [3:0] memory_wait_cycle_setting,
  output logic [cgc_pkg::DIV_N-1:0] clk_tick,
  output logic [31:0] module_stop_a,
  output logic [31:0] module_stop_d,
  output logic all_module_stop_ok,
  output logic irq
);
  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  logic [1:0] src_req;
  logic [15:0] pll_ctrl;
  logic [DIV_N*DIV_W-1:0] div_ctrl;
  logic [3:0] mem_wait;
  logic [31:0] mstop_a;
  logic [31:0] mstop_d;
  logic [ST_W-1:0] status;
  logic [ST_W-1:0] irq_en;
  cgc_src_t cur_src;
  cgc_sw_state_t sw_state;
  logic [3:0] gap_cnt;
  logic osc_stop_seen;
  cgc_src_t target_src;

  wire wr_en = psel & penable & pwrite;
  wire rd_ok = (paddr[1:0] == 2'h0) && (paddr <= OFF_CUR_SRC);
  wire wr_src = wr_en & (paddr == OFF_SRC_CTRL);
  wire wr_pll = wr_en & (paddr == OFF_PLL_CTRL);
  wire wr_div = wr_en & (paddr == OFF_DIV_CTRL);
  wire wr_wait = wr_en & (paddr == OFF_MEM_WAIT);
  wire wr_ma = wr_en & (paddr == OFF_MSTOP_A);
  wire wr_md = wr_en & (paddr == OFF_MSTOP_D);
  wire wr_ien = wr_en & (paddr == OFF_IRQ_EN);
  wire wr_clr = wr_en & (paddr == OFF_IRQ_CLR);

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~rd_ok;

  // Half-step multiplier range check
  function automatic logic mul_ok(input logic [5:0] m);
    mul_ok = (m >= PLL_MUL_MIN) && (m <= PLL_MUL_MAX);
  endfunction

  wire [5:0] wr_mul = pwdata[PLL_MUL_LSB +: PLL_MUL_W];
  wire mul_bad = wr_pll & ~mul_ok(wr_mul);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata <= 32'h0;
    end else if (psel & ~penable & ~pwrite) begin
      unique case (paddr)
        OFF_SRC_CTRL: prdata <= {30'h0, src_req};
        OFF_PLL_CTRL: prdata <= {16'h0, pll_ctrl};
        OFF_DIV_CTRL: prdata <= {11'h0, div_ctrl};
        OFF_MEM_WAIT: prdata <= {28'h0, mem_wait};
        OFF_MSTOP_A: prdata <= mstop_a;
        OFF_MSTOP_D: prdata <= mstop_d;
        OFF_STATUS: prdata <= {29'h0, status};
        OFF_IRQ_EN: prdata <= {29'h0, irq_en};
        OFF_CUR_SRC: prdata <= {30'h0, cur_src};
        default: prdata <= 32'h0;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      src_req <= CGC_SRC_LOW_OSC;
      pll_ctrl <= {2'h0, PLL_MUL_RST, 8'h0};
      div_ctrl <= '0;
      mem_wait <= 4'h0;
      mstop_a <= MSTOP_RST;
      mstop_d <= MSTOP_RST;
      irq_en <= '0;
    end else begin
      if (wr_src) src_req <= pwdata[1:0];
      if (wr_pll && !mul_bad) pll_ctrl <= {2'h0, wr_mul, 3'h0, pwdata[PLL_REF_BIT], 3'h0, pwdata[PLL_EN_BIT]};
      if (wr_div) div_ctrl <= pwdata[DIV_N*DIV_W-1:0];
      if (wr_wait) mem_wait <= pwdata[3:0];
      if (wr_ma) mstop_a <= pwdata;
      if (wr_md) mstop_d <= pwdata;
      if (wr_ien) irq_en <= pwdata[ST_W-1:0];
    end
  end

  assign pll_multiplier_field = pll_ctrl[PLL_MUL_LSB +: PLL_MUL_W];
  assign pll_enable = pll_ctrl[PLL_EN_BIT];
  assign pll_ref_high_osc = pll_ctrl[PLL_REF_BIT];
  assign memory_wait_cycle_setting = mem_wait;
  assign module_stop_a = mstop_a;
  assign module_stop_d = mstop_d;
  assign all_module_stop_ok = ((mstop_a & MSTOP_A_ALL) == MSTOP_A_ALL) &&
    ((mstop_d & MSTOP_D_ALL) == MSTOP_D_ALL);

  // ------------------------------------------------------------
  // Source changeover
  // ------------------------------------------------------------
  wire pll_int_run = (cur_src == CGC_SRC_PLL) & pll_ref_high_osc;
  wire fallback = osc_stop_seen & ~pll_int_run;
  wire main_based = (cur_src == CGC_SRC_MAIN) | ((cur_src == CGC_SRC_PLL) & ~pll_ref_high_osc);
  wire need_fb = main_osc_stopped & main_based & ~pll_int_run;

  always_comb begin
    if (fallback) target_src = CGC_SRC_LOW_OSC;
    else target_src = cgc_src_t'(src_req);
  end

  // Gate all derived ticks, switch, then release: no short pulses
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sw_state <= CGC_RUN;
      cur_src <= CGC_SRC_LOW_OSC;
      gap_cnt <= 4'h0;
      osc_stop_seen <= 1'b0;
    end else begin
      if (need_fb) osc_stop_seen <= 1'b1;
      else if (src_req != CGC_SRC_MAIN && src_req != CGC_SRC_PLL) osc_stop_seen <= 1'b0;
      unique case (sw_state)
        CGC_RUN: begin
          if (target_src != cur_src) begin
            sw_state <= CGC_GATE_OFF;
            gap_cnt <= SW_GAP_CYC;
          end
        end
        CGC_GATE_OFF: begin
          if (gap_cnt == 4'h0) begin
            cur_src <= target_src;
            sw_state <= CGC_GATE_ON;
            gap_cnt <= SW_GAP_CYC;
          end else begin
            gap_cnt <= gap_cnt - 4'h1;
          end
        end
        CGC_GATE_ON: begin
          if (gap_cnt == 4'h0) sw_state <= CGC_RUN;
          else gap_cnt <= gap_cnt - 4'h1;
        end
      endcase
    end
  end

  assign clk_src_sel = cur_src;

  // ------------------------------------------------------------
  // Divider bank: timer/fast clocks gated together
  // ------------------------------------------------------------
  cgc_div_if div_bus ();
  assign div_bus.ratio = div_ctrl;
  assign div_bus.gate = (sw_state != CGC_RUN);
  assign clk_tick = div_bus.tick;

  cgc_div_bank u_div (
    .clk(clk),
    .sys_rst(sys_rst),
    .dv(div_bus)
  );

  // ------------------------------------------------------------
  // Interrupt status
  // ------------------------------------------------------------
  wire sw_done = (sw_state == CGC_GATE_ON) && (gap_cnt == 4'h0);
  wire [ST_W-1:0] ev = {mul_bad, sw_done, need_fb & ~osc_stop_seen};
  wire [ST_W-1:0] clr = wr_clr ? pwdata[ST_W-1:0] : '0;

  always_ff @(posedge clk) begin
    if (sys_rst) status <= '0;
    else status <= ev | (status & ~clr);
  end

  assign irq = |(status & irq_en);

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_fallback_low_osc: assert property (@(posedge clk) disable iff (sys_rst)
    (need_fb && sw_state == CGC_RUN && cur_src != CGC_SRC_LOW_OSC) |-> ##[1:24] cur_src == CGC_SRC_LOW_OSC)
    else $error("no fallback to low-speed oscillator");
  a_int_pll_kept: assert property (@(posedge clk) disable iff (sys_rst)
    (pll_int_run && src_req == CGC_SRC_PLL && !wr_src && !wr_pll) |=> cur_src == CGC_SRC_PLL)
    else $error("high-speed PLL source dropped");
  a_mul_in_range: assert property (@(posedge clk) disable iff (sys_rst)
    mul_ok(pll_multiplier_field)) else $error("multiplier out of range");
  a_mul_bad_kept: assert property (@(posedge clk) disable iff (sys_rst)
    mul_bad |=> $stable(pll_multiplier_field) && status[ST_MUL_ERR])
    else $error("bad multiplier accepted");
  a_switch_gated: assert property (@(posedge clk) disable iff (sys_rst)
    $changed(cur_src) |-> div_bus.gate && $past(div_bus.gate)) else $error("ungated switch");
  a_switch_follows: assert property (@(posedge clk) disable iff (sys_rst)
    (wr_src && pwdata[1:0] == CGC_SRC_PLL && !osc_stop_seen && !main_osc_stopped)
      |-> ##[1:24] cur_src == CGC_SRC_PLL) else $error("switch not taken");
  a_stop_ok: assert property (@(posedge clk) disable iff (sys_rst)
    all_module_stop_ok |-> mstop_a[24] && mstop_a[27] && mstop_a[29] && mstop_d[7:0] == 8'hff)
    else $error("module stop flag wrong");
  a_irq_level: assert property (@(posedge clk) disable iff (sys_rst)
    ((ev & irq_en) != '0 && !wr_ien) |=> irq) else $error("interrupt missed");
endmodule

// *** bench/cgc_tb.sv ***
// Testbench: register-level self-checking bench of the clock generation control
`timescale 1ns/1ps
module testbench;
  import cgc_pkg::*;
  logic clk, sys_rst, psel, penable, pwrite, main_osc_stopped, pready, pslverr, serr;
  logic irq, pll_enable, pll_ref_high_osc, all_module_stop_ok, m_ok;
  logic [31:0] dw;
  // Log2 ratios: system, bus, flash, fast, general, timer, converter
  int dr [DIV_N] = '{0, 1, 1, 1, 2, 0, 2};
  int tk [DIV_N];
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat, seed, m_st, ma, md;
  logic [5:0] pll_multiplier_field, m_mul, c;
  logic [3:0] memory_wait_cycle_setting;
  logic [DIV_N-1:0] clk_tick;
  logic [31:0] module_stop_a, module_stop_d;
  cgc_src_t clk_src_sel;
  int errors, checked;

  cgc_top u_dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .main_osc_stopped(main_osc_stopped), .clk_src_sel(clk_src_sel),
    .pll_multiplier_field(pll_multiplier_field), .pll_enable(pll_enable), .pll_ref_high_osc(pll_ref_high_osc),
    .memory_wait_cycle_setting(memory_wait_cycle_setting), .clk_tick(clk_tick),
    .module_stop_a(module_stop_a), .module_stop_d(module_stop_d),
    .all_module_stop_ok(all_module_stop_ok), .irq(irq));

  // ----------------------------------------
  // Clock, helpers
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Let the write settle before outputs are compared
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk("rdata", exp, rdat);
  endtask

  // Watches changeover: ticks must be quiet when the source moves
  task automatic wait_src(input logic [1:0] s);
    logic [1:0] prev;
    int q;
    prev = clk_src_sel;
    q = 99;
    repeat (60) begin
      @(posedge clk);
      #1;
      if (clk_src_sel !== prev) q = 0;
      else q++;
      if (q <= 8) chk("tick_gap", 32'h0, 32'(clk_tick));
      prev = clk_src_sel;
    end
    chk("src", 32'(s), 32'(clk_src_sel));
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    finish_test;
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    sys_rst = 1'b1;
    {psel, penable, pwrite, main_osc_stopped} = 4'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    errors = 0;
    checked = 0;
    seed = 32'hd957dcd8;
    m_st = 32'h0;
    m_mul = PLL_MUL_RST;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    rd(OFF_SRC_CTRL, 32'h0);
    rd(OFF_CUR_SRC, 32'h0);
    rd(OFF_STATUS, 32'h0);
    rd(OFF_MSTOP_A, MSTOP_RST);
    chk("stop_ok", 32'h1, 32'(all_module_stop_ok));
    rd(8'h40, 32'h0);
    chk("slverr", 32'h1, 32'(serr));
    apb(1'b1, OFF_MEM_WAIT, 32'h0000000a);
    chk("mem_wait", 32'ha, 32'(memory_wait_cycle_setting));
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      ma = (i == 5) ? MSTOP_A_ALL : seed;
      seed = lfsr(seed);
      md = (i == 5) ? MSTOP_D_ALL : (seed | 32'h000000f7);
      apb(1'b1, OFF_MSTOP_A, ma);
      apb(1'b1, OFF_MSTOP_D, md);
      chk("stop_a", ma, module_stop_a);
      chk("stop_d", md, module_stop_d);
      m_ok = ((ma & MSTOP_A_ALL) == MSTOP_A_ALL) && ((md & MSTOP_D_ALL) == MSTOP_D_ALL);
      chk("stop_ok", 32'(m_ok), 32'(all_module_stop_ok));
    end
    for (int i = 0; i < 5; i++) begin
      seed = lfsr(seed);
      c = (i == 0) ? 6'h12 : (i == 1) ? 6'h13 : (i == 2) ? 6'h3b : (i == 3) ? 6'h3c : 6'h13 + 6'(seed % 41);
      m_ok = c >= PLL_MUL_MIN && c <= PLL_MUL_MAX;
      if (m_ok) m_mul = c;
      else m_st[ST_MUL_ERR] = 1'b1;
      apb(1'b1, OFF_PLL_CTRL, (32'(c) << PLL_MUL_LSB) | 32'h1);
      chk("pll_mul", 32'(m_mul), 32'(pll_multiplier_field));
      rd(OFF_STATUS, m_st);
    end
    chk("pll_en", 32'h1, 32'(pll_enable));
    apb(1'b1, OFF_IRQ_EN, 32'h7);
    chk("irq", 32'h1, 32'(irq));
    apb(1'b1, OFF_IRQ_CLR, 32'h4);
    m_st = 32'h0;
    chk("irq", 32'h0, 32'(irq));
    apb(1'b1, OFF_SRC_CTRL, 32'h3);
    wait_src(2'h3);
    rd(OFF_CUR_SRC, 32'h3);
    rd(OFF_STATUS, 32'h2);
    apb(1'b1, OFF_IRQ_CLR, 32'h2);
    apb(1'b1, OFF_PLL_CTRL, (32'(m_mul) << PLL_MUL_LSB) | 32'h11);
    chk("ref", 32'h1, 32'(pll_ref_high_osc));
    main_osc_stopped <= 1'b1;
    wait_src(2'h3);
    rd(OFF_STATUS, 32'h0);
    main_osc_stopped <= 1'b0;
    apb(1'b1, OFF_PLL_CTRL, (32'(m_mul) << PLL_MUL_LSB) | 32'h1);
    main_osc_stopped <= 1'b1;
    wait_src(2'h0);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("fallback", 32'h1, 32'(rdat[ST_OSC_STOP]));
    chk("irq", 32'h1, 32'(irq));
    main_osc_stopped <= 1'b0;
    apb(1'b1, OFF_SRC_CTRL, 32'h1);
    wait_src(2'h1);
    dw = 32'h0;
    for (int i = 0; i < DIV_N; i++) dw = dw | (32'(dr[i]) << (i * DIV_W));
    apb(1'b1, OFF_DIV_CTRL, dw);
    rd(OFF_DIV_CTRL, dw);
    for (int i = 0; i < DIV_N; i++) tk[i] = 0;
    repeat (128) begin
      @(posedge clk);
      #1;
      for (int i = 0; i < DIV_N; i++) tk[i] += int'(clk_tick[i]);
    end
    for (int i = 0; i < DIV_N; i++) chk("tick_count", 32'(128 >> dr[i]), 32'(tk[i]));
    apb(1'b1, OFF_IRQ_CLR, 32'h7);
    apb(1'b1, OFF_SRC_CTRL, 32'h2);
    wait_src(2'h2);
    @(posedge clk);
    main_osc_stopped <= 1'b1;
    wait_src(2'h0);
    rd(OFF_STATUS, 32'h3);
    chk("irq", 32'h1, 32'(irq));
    apb(1'b1, OFF_IRQ_EN, 32'h0);
    chk("irq_mask", 32'h0, 32'(irq));
    finish_test;
  end
endmodule
